// [rtl/bscc_top.sv]
// Boot strap decoder, clock ratio control and bus pin control.
// Assumes pclk is the core clock and straps are steady at reset release.
//
// What this block does
// - EPROM strap alone: drive boot select as chip-select
// - Other modes: boot select is input, decodes host/link
// - All straps low: no boot, run external memory
// - Core clock is 2, 3 or 4 times input
// - External port cycles at the input clock rate
// - Bus clock driven only by master without host grant
// - Bus clock keeper only on ID 00x
// - Master without host grant drives fetch indicator low during external fetch
// - Reset held at power-up; restart at reset vector
// - Link pull-downs switched by pulldown disable bit
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "bscc_params.svh"

module bscc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`BSCC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	input wire bscc_pkg::bscc_strap_s strap_in,
	input wire logic boot_mem_select_i,
	output var bscc_pkg::bscc_pin_s boot_mem_select_drv,
	input wire logic boot_rom_access,
	input wire logic bus_master,
	input wire logic host_grant_n,
	input wire logic [2:0] proc_id,
	input wire logic ext_fetch,
	input wire logic test_reset_n,
	output var bscc_pkg::bscc_pin_s bus_clock_out_drv,
	output var logic bus_clock_keeper_en,
	output var bscc_pkg::bscc_pin_s core_fetch_ind_drv,
	output var logic ext_cycle_en,
	output var logic link_pulldown_en,
	output var logic core_start,
	output var logic [31:0] fetch_vector
);
	import bscc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Strap snapshot

	bscc_strap_s strap_r;
	logic bms_strap_r;
	logic strap_valid_r;
	bscc_boot_e mode;
	logic [2:0] ratio;
	logic ratio_rsvd;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_r <= '0;
			bms_strap_r <= 1'b0;
			strap_valid_r <= 1'b0;
		end else if (!strap_valid_r) begin
			strap_r <= strap_in;
			bms_strap_r <= boot_mem_select_i;
			strap_valid_r <= 1'b1;
		end
	end

	// Boot mode from the frozen straps
	always_comb begin
		mode = BSCC_BOOT_RSVD;
		if (strap_r.eprom_boot_sel && !strap_r.link_boot_sel) begin
			mode = BSCC_BOOT_EPROM;
		end else if (!strap_r.eprom_boot_sel && bms_strap_r) begin
			mode = strap_r.link_boot_sel ? BSCC_BOOT_LINK : BSCC_BOOT_HOST;
		end else if (!strap_r.eprom_boot_sel && !strap_r.link_boot_sel) begin
			mode = BSCC_BOOT_NONE;
		end
	end

	// Ratio from the frozen straps; unknown codes fall back to the lowest
	always_comb begin
		ratio_rsvd = 1'b0;
		unique case (strap_r.core_ratio_cfg)
			`BSCC_CFG_R2: ratio = `BSCC_RATIO_2;
			`BSCC_CFG_R3: ratio = `BSCC_RATIO_3;
			`BSCC_CFG_R4: ratio = `BSCC_RATIO_4;
			default: begin
				ratio = `BSCC_RATIO_2;
				ratio_rsvd = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Start after reset

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_start <= 1'b0;
			fetch_vector <= `BSCC_RESET_VECTOR;
		end else begin
			core_start <= !strap_valid_r;
			fetch_vector <= `BSCC_RESET_VECTOR;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input-clock rate from the core clock

	logic clk_phase;

	bscc_ratio_div u_div (
		.clk(pclk),
		.rst_n(presetn),
		.run(strap_valid_r),
		.ratio(ratio),
		.tick(ext_cycle_en),
		.phase_hi(clk_phase)
	);

	logic [31:0] bcnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcnt_r <= 32'h0000_0000;
		end else if (ext_cycle_en) begin
			bcnt_r <= bcnt_r + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin control

	logic bus_owner;

	assign bus_owner = bus_master && host_grant_n;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_mem_select_drv <= '0;
		end else begin
			boot_mem_select_drv.o <= !boot_rom_access;
			boot_mem_select_drv.oe <= strap_valid_r && (mode == BSCC_BOOT_EPROM);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_clock_out_drv <= '0;
			bus_clock_keeper_en <= 1'b0;
		end else begin
			bus_clock_out_drv.o <= clk_phase;
			bus_clock_out_drv.oe <= strap_valid_r && bus_owner;
			bus_clock_keeper_en <= (proc_id[2:1] == `BSCC_KEEPER_ID);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_fetch_ind_drv <= '0;
		end else begin
			core_fetch_ind_drv.o <= !ext_fetch;
			core_fetch_ind_drv.oe <= strap_valid_r && bus_owner;
		end
	end

	// Sticky: the board has pulsed or is holding the test reset
	logic trst_seen_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trst_seen_r <= 1'b0;
		end else if (!test_reset_n) begin
			trst_seen_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave

	logic ctrl_pdd_r;
	logic acc_done;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_bcnt;
	logic hit_vec;
	logic [31:0] stat_word;
	logic [31:0] rd_word;

	assign acc_done = psel && penable && pready;
	assign hit_ctrl = (paddr == `BSCC_CTRL_OFS);
	assign hit_stat = (paddr == `BSCC_STAT_OFS);
	assign hit_bcnt = (paddr == `BSCC_BCNT_OFS);
	assign hit_vec = (paddr == `BSCC_VEC_OFS);

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[`BSCC_ST_MODE_LSB +: 3] = mode;
		stat_word[`BSCC_ST_RATIO_LSB +: 3] = ratio;
		stat_word[`BSCC_ST_VALID_BIT] = strap_valid_r;
		stat_word[`BSCC_ST_RRSV_BIT] = ratio_rsvd;
		stat_word[`BSCC_ST_MASTER_BIT] = bus_master;
		stat_word[`BSCC_ST_HGRANT_BIT] = !host_grant_n;
		stat_word[`BSCC_ST_TRST_BIT] = trst_seen_r;
		stat_word[`BSCC_ST_CLKOE_BIT] = bus_clock_out_drv.oe;
		stat_word[`BSCC_ST_ID_LSB +: 3] = proc_id;
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_word[`BSCC_CTRL_PDD_BIT] = ctrl_pdd_r;
		end else if (hit_stat) begin
			rd_word = stat_word;
		end else if (hit_bcnt) begin
			rd_word = bcnt_r;
		end else if (hit_vec) begin
			rd_word = fetch_vector;
		end
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !(hit_ctrl || hit_stat || hit_bcnt || hit_vec);
			if (psel && penable && !pready && !pwrite) begin
				prdata <= rd_word;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_pdd_r <= `BSCC_CTRL_RST;
		end else if (acc_done && pwrite && hit_ctrl && pstrb[0]) begin
			ctrl_pdd_r <= pwdata[`BSCC_CTRL_PDD_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_pulldown_en <= !`BSCC_CTRL_RST;
		end else begin
			link_pulldown_en <= !ctrl_pdd_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence ctrl_write_s;
		acc_done && pwrite && hit_ctrl && pstrb[0];
	endsequence

	sequence pd_follow_s(logic v);
		(ctrl_pdd_r == v) ##1 (link_pulldown_en == !v);
	endsequence

	eprom_drive_a: assert property (
		strap_valid_r && strap_r.eprom_boot_sel && !strap_r.link_boot_sel
		|=> boot_mem_select_drv.oe && (boot_mem_select_drv.o == !$past(boot_rom_access)))
		else $error("boot select not driven as chip select in EPROM mode");

	bms_input_a: assert property (
		!(strap_r.eprom_boot_sel && !strap_r.link_boot_sel) |=> !boot_mem_select_drv.oe)
		else $error("boot select driven outside EPROM mode");

	noboot_mode_a: assert property (
		strap_valid_r && !strap_r.eprom_boot_sel && !strap_r.link_boot_sel && !bms_strap_r
		|-> mode == BSCC_BOOT_NONE)
		else $error("all-low straps not decoded as no boot");

	ratio_three_a: assert property (
		ext_cycle_en && ratio == `BSCC_RATIO_3 |=> !ext_cycle_en [*2] ##1 ext_cycle_en)
		else $error("input clock period wrong for ratio three");

	ratio_four_a: assert property (
		ext_cycle_en && ratio == `BSCC_RATIO_4 |=> !ext_cycle_en [*3] ##1 ext_cycle_en)
		else $error("input clock period wrong for ratio four");

	clk_tristate_a: assert property (
		!bus_master || !host_grant_n |=> !bus_clock_out_drv.oe)
		else $error("bus clock driven without bus ownership");

	// Guarded by capture: the keeper flop is still in reset on the first edge after release
	keeper_id_a: assert property (
		strap_valid_r |=> bus_clock_keeper_en == ($past(proc_id[2:1]) == `BSCC_KEEPER_ID))
		else $error("keeper enable does not follow ID");

	fetch_ind_a: assert property (
		strap_valid_r && bus_owner && ext_fetch |=> core_fetch_ind_drv.oe && !core_fetch_ind_drv.o)
		else $error("fetch indicator not driven low during fetch");

	start_pulse_a: assert property (
		$rose(strap_valid_r) |-> core_start ##1 !core_start && fetch_vector == `BSCC_RESET_VECTOR)
		else $error("start pulse after reset wrong");

	pulldown_a: assert property (
		ctrl_write_s |=> pd_follow_s($past(pwdata[`BSCC_CTRL_PDD_BIT])))
		else $error("pull-down enable does not follow control bit");

	strap_hold_a: assert property (
		strap_valid_r |=> $stable(strap_r) && $stable(bms_strap_r) && strap_valid_r)
		else $error("strap snapshot changed after capture");

	ratio_two_a: assert property (
		ext_cycle_en && ratio == `BSCC_RATIO_2 |=> !ext_cycle_en ##1 ext_cycle_en)
		else $error("input clock period wrong for ratio two");

	clk_drive_a: assert property (
		strap_valid_r && bus_owner |=> bus_clock_out_drv.oe)
		else $error("bus master does not drive the bus clock");

	host_fetch_a: assert property (
		!host_grant_n |=> !core_fetch_ind_drv.oe)
		else $error("fetch indicator driven while host owns the bus");

	// Guarded by capture so a test reset held low through processor reset is allowed
	trst_sticky_a: assert property (
		strap_valid_r && !test_reset_n |=> trst_seen_r)
		else $error("test reset not recorded");

	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("ready held for more than one cycle");

endmodule

`default_nettype wire

// [common/bscc_params.svh]
// Constants of the boot strap and clock ratio block.
// Included by the package and by every design file that needs an offset.
`ifndef BSCC_PARAMS_SVH
`define BSCC_PARAMS_SVH

// Register map, byte addresses on the APB
`define BSCC_ADDR_W 12
`define BSCC_CTRL_OFS 12'h000
`define BSCC_STAT_OFS 12'h004
`define BSCC_BCNT_OFS 12'h008
`define BSCC_VEC_OFS 12'h00c

// Control register
`define BSCC_CTRL_PDD_BIT 0
`define BSCC_CTRL_RST 1'b0

// Status register fields
`define BSCC_ST_MODE_LSB 0
`define BSCC_ST_RATIO_LSB 4
`define BSCC_ST_VALID_BIT 8
`define BSCC_ST_RRSV_BIT 9
`define BSCC_ST_MASTER_BIT 10
`define BSCC_ST_HGRANT_BIT 11
`define BSCC_ST_TRST_BIT 12
`define BSCC_ST_CLKOE_BIT 13
`define BSCC_ST_ID_LSB 16

// Ratio strap codes and core-to-input clock ratios
`define BSCC_CFG_R2 4'h0
`define BSCC_CFG_R3 4'h1
`define BSCC_CFG_R4 4'h2
`define BSCC_RATIO_2 3'h2
`define BSCC_RATIO_3 3'h3
`define BSCC_RATIO_4 3'h4

// Keeper is enabled when the upper two ID bits match this
`define BSCC_KEEPER_ID 2'h0

// Program address taken after reset
`define BSCC_RESET_VECTOR 32'h0000_0000

`endif

// [common/bscc_pkg.sv]
// Types shared by the boot strap and clock ratio block.
// Assumes bscc_params.svh is on the include path.
`default_nettype none
`include "bscc_params.svh"

package bscc_pkg;

	typedef enum logic [2:0] {
		BSCC_BOOT_NONE,
		BSCC_BOOT_EPROM,
		BSCC_BOOT_HOST,
		BSCC_BOOT_LINK,
		BSCC_BOOT_RSVD
	} bscc_boot_e;

	typedef struct packed {
		logic eprom_boot_sel;
		logic link_boot_sel;
		logic [3:0] core_ratio_cfg;
	} bscc_strap_s;

	typedef struct packed {
		logic o;
		logic oe;
	} bscc_pin_s;

endpackage

`default_nettype wire

// [rtl/bscc_ratio_div.sv]
// Divider making the input-clock rate from the core clock.
// Assumes ratio is held steady while run is high.
`timescale 1ns/1ns
`default_nettype none

module bscc_ratio_div (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [2:0] ratio,
	output var logic tick,
	output var logic phase_hi
);
	import bscc_pkg::*;

	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic [2:0] last;
	logic [2:0] half;

	always_comb begin
		last = ratio - 3'h1;
		half = (ratio + 3'h1) >> 1;
		cnt_nxt = (cnt_r == last) ? 3'h0 : cnt_r + 3'h1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 3'h0;
			tick <= 1'b0;
			phase_hi <= 1'b0;
		end else if (!run) begin
			cnt_r <= 3'h0;
			tick <= 1'b0;
			phase_hi <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick <= (cnt_r == last);
			phase_hi <= (cnt_nxt < half);
		end
	end

endmodule

`default_nettype wire

// [sim/bscc_boot_src.sv]
// Board side of the boot select pin: strap level and boot source.
// Assumes the design drives the pin through an {o,oe} pair.
`timescale 1ns/1ns
`default_nettype none

module bscc_boot_src (
	input wire bscc_pkg::bscc_pin_s drv,
	input wire logic board_level,
	output var logic line
);
	import bscc_pkg::*;
	// Board strap shows unless the device drives the select
	always_comb begin
		line = drv.oe ? drv.o : board_level;
	end
endmodule

`default_nettype wire

// [sim/boot_strap_and_clock_config_test.sv]
// Self-checking bench for the boot strap and clock ratio block.
// Assumes bscc_pkg, bscc_params.svh and bscc_boot_src are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "bscc_params.svh"

module boot_strap_and_clock_config_test;
	import bscc_pkg::*;
	typedef struct packed {logic [6:0] s; logic [2:0] mode; logic [2:0] n; logic oe;} bscc_row_s;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd, vec;
	logic pready, pslverr, err, keep, ext_en, pd_en, start, bms_line, last;
	bscc_strap_s strap = '0;
	logic bms_board = 0, rom = 0, bm = 0, hg_n = 1, fetch = 0, trst_n = 1;
	logic [2:0] pid = 3'h1;
	bscc_pin_s bms_drv, clk_drv, cif_drv;
	int n_errors = 0, compares = 0, cnt;
	// Straps {eprom, link, select pin, ratio code}, mode, ratio, select driven
	bscc_row_s rows [6] = '{{7'h50, 3'h1, 3'h2, 1'h1}, {7'h11, 3'h2, 3'h3, 1'h0},
		{7'h32, 3'h3, 3'h4, 1'h0}, {7'h00, 3'h0, 3'h2, 1'h0},
		{7'h20, 3'h4, 3'h2, 1'h0}, {7'h63, 3'h4, 3'h2, 1'h0}};

	initial forever #4 pclk = ~pclk;

	bscc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .strap_in(strap), .boot_mem_select_i(bms_line),
		.boot_mem_select_drv(bms_drv), .boot_rom_access(rom), .bus_master(bm),
		.host_grant_n(hg_n), .proc_id(pid), .ext_fetch(fetch), .test_reset_n(trst_n),
		.bus_clock_out_drv(clk_drv), .bus_clock_keeper_en(keep), .core_fetch_ind_drv(cif_drv),
		.ext_cycle_en(ext_en), .link_pulldown_en(pd_en), .core_start(start), .fetch_vector(vec));

	bscc_boot_src partner (.drv(bms_drv), .board_level(bms_board), .line(bms_line));

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic stop_test;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1) begin
			n_errors++;
			stop_test();
		end
	endtask

	task automatic rst;
		presetn <= 1'b0;
		tick(4);
		presetn <= 1'b1;
		tick(2);
		chk("start pulse", 1, start);
		tick(1);
		chk("start end", 0, start);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		for (int k = 0; k < 6; k++) begin
			strap <= {rows[k].s[6:5], rows[k].s[3:0]};
			bms_board <= rows[k].s[4];
			rom <= 1'b1;
			rst();
			strap <= ~strap;
			apb(1'b0, `BSCC_STAT_OFS, 32'h0, rd, err);
			chk("mode", rows[k].mode, rd[2:0]);
			chk("ratio", rows[k].n, rd[6:4]);
			chk("ratio reserved", rows[k].s[3:0] > 4'h2, rd[9]);
			chk("boot select", rows[k].oe ? 1'b0 : rows[k].s[4], bms_line);
			cnt = 0;
			repeat (24) begin
				@(posedge pclk);
				if (ext_en === 1'b1)
					cnt++;
			end
			chk("ext rate", 24 / rows[k].n, cnt);
		end
		// Bus clock and fetch indicator ownership
		for (int k = 0; k < 3; k++) begin
			bm <= (k != 1);
			hg_n <= (k != 2);
			fetch <= (k != 1);
			tick(3);
			chk("clk oe", k == 0, clk_drv.oe);
			chk("fetch pin", {k == 0, k == 1}, {cif_drv.oe, cif_drv.o});
		end
		bm <= 1'b1;
		hg_n <= 1'b1;
		tick(3);
		cnt = 0;
		last = clk_drv.o;
		repeat (24) begin
			@(posedge pclk);
			if (clk_drv.o === 1'b1 && last === 1'b0)
				cnt++;
			last = clk_drv.o;
		end
		chk("bus clk rate", 12, cnt);
		pid <= 3'h2;
		tick(3);
		chk("keeper", 0, keep);
		pid <= 3'h1;
		tick(3);
		chk("keeper", 1, keep);
		apb(1'b1, `BSCC_CTRL_OFS, 32'h1, rd, err);
		tick(2);
		chk("pulldown", 0, pd_en);
		apb(1'b0, `BSCC_CTRL_OFS, 32'h0, rd, err);
		chk("ctrl", 1, rd);
		apb(1'b1, `BSCC_CTRL_OFS, 32'h0, rd, err);
		tick(2);
		chk("pulldown", 1, pd_en);
		apb(1'b0, 12'h010, 32'h0, rd, err);
		chk("slverr", 1, err);
		chk("unmapped data", 0, rd);
		trst_n <= 1'b0;
		tick(1);
		trst_n <= 1'b1;
		apb(1'b0, `BSCC_STAT_OFS, 32'h0, rd, err);
		chk("test reset seen", 1, rd[12]);
		apb(1'b0, `BSCC_VEC_OFS, 32'h0, rd, err);
		chk("vector reg", `BSCC_RESET_VECTOR, rd);
		chk("vector", `BSCC_RESET_VECTOR, vec);
		apb(1'b0, `BSCC_BCNT_OFS, 32'h0, rd, err);
		cnt = rd;
		apb(1'b0, `BSCC_BCNT_OFS, 32'h0, rd, err);
		chk("pulse count", 2, rd - cnt);
		stop_test();
	end
endmodule

`default_nettype wire
